// ==== rtl/dt_timer.sv ====
// dual 16-bit timer block with 32-bit one-shot, periodic and real-time modes
//
// What this block does
// - two 16-bit counters that run alone or joined as one 32-bit timer or clock
// - trigger outputs of all timer blocks are ORed outside before the converter
// - reset leaves block idle, controls cleared, counters and loads at FFFF
// - reset leaves both prescale registers at zero
// - configuration 0 gives 32-bit one-shot/periodic, 1 gives 32-bit clock mode
// - configuration 4 gives global 16-bit mode for both counters
// - in 32-bit modes a load write fills second load high, first load low
// - in 32-bit modes first value read returns second count high, first low
// - only the first mode field picks one-shot or periodic in 32-bit mode
// - enabled counter counts down and reloads from joined loads after zero
// - after reload a one-shot stops and clears enable, periodic keeps going
// - zero sets sticky raw time-out flag; masked copy and interrupt when enabled
// - trigger pulses at zero only when the first trigger enable is set
// - a load write while counting is taken on the next cycle
// - with stall enable the counter holds while the processor is halted
// - clock mode counts up from 1, set only on the first clock selection after reset; load writes leave the count alone
// - external 32.768 kHz on even capture pin is divided to a 1 Hz tick
// - clock count equal to match rolls to zero and keeps counting
// - clock match sets raw and masked flags, cleared by the clock clear bit
// - with clock enable set the stall bits are ignored during halt
// - 8-bit prescaler only acts in 16-bit one-shot and periodic modes
//
// Chosen here: the Wishbone register port and the register addresses.
`include "dt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dt_timer
  import dt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins and system
  input wire logic capture_pin_i,
  input wire logic cpu_halt_i,
  output logic irq_o,
  output logic adc_trig_o
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  dt_bus_req_t bus;
  logic ack_reg;
  assign bus.adr = adr_i;
  assign bus.dat = dat_i;
  assign bus.we = we_i;
  assign bus.req = cyc_i & stb_i & ~ack_reg;
  wire wr = bus.req & bus.we & (sel_i == 4'hF);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit
  logic [2:0] cfg_reg;
  logic [1:0] amode_reg, bmode_reg;
  logic [15:0] ctl_reg;
  logic [3:0] imr_reg, ris_reg;
  logic [15:0] ailr_reg, bilr_reg, acnt_reg, bcnt_reg;
  logic [31:0] amatch_reg;
  logic [7:0] apr_reg, bpr_reg, apre_reg, bpre_reg;
  logic [31:0] rdat;
  logic rtc_seen_reg;
  wire mode32 = (cfg_reg == `DT_CFG_32);
  wire mode_rtc = (cfg_reg == `DT_CFG_RTC);
  wire mode16 = (cfg_reg == `DT_CFG_16);
  wire [31:0] cnt32 = {bcnt_reg, acnt_reg};
  wire [31:0] ilr32 = {bilr_reg, ailr_reg};
  wire [3:0] mis = ris_reg & imr_reg;
  wire wr_ctl = wr & hit(bus.adr, `DT_OFF_CTL);
  wire wr_ailr = wr & hit(bus.adr, `DT_OFF_AILR);
  wire wr_bilr = wr & hit(bus.adr, `DT_OFF_BILR);
  wire wr_icr = wr & hit(bus.adr, `DT_OFF_ICR);
  wire wr_cfg = wr & hit(bus.adr, `DT_OFF_CFG);
  // ------------------------------------------------------------
  // pin synchroniser and 1 Hz divider
  // ------------------------------------------------------------
  logic pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic [15:0] div_reg;
  always_ff @(posedge clk_i) begin
    pin_s1_reg <= capture_pin_i;
    pin_s2_reg <= pin_s1_reg;
    pin_d_reg <= pin_s2_reg;
  end
  wire pin_rise = pin_s2_reg & ~pin_d_reg;
  wire div_wrap = pin_rise & (div_reg == `DT_RTC_DIV - 16'h0001);
  wire sec_tick = div_wrap & ctl_reg[`DT_CTL_REALTIME_ENABLE_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i | ~ctl_reg[`DT_CTL_REALTIME_ENABLE_BIT]) begin
      div_reg <= 16'h0000;
    end else if (pin_rise) begin
      div_reg <= div_wrap ? 16'h0000 : div_reg + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // count control
  // ------------------------------------------------------------
  // stall on halt
  wire a_stall = ctl_reg[`DT_CTL_ASTALL] & cpu_halt_i & ~ctl_reg[`DT_CTL_REALTIME_ENABLE_BIT];
  wire b_stall = ctl_reg[`DT_CTL_BSTALL] & cpu_halt_i & ~ctl_reg[`DT_CTL_REALTIME_ENABLE_BIT];
  wire a_en = ctl_reg[`DT_CTL_AEN];
  wire b_en = ctl_reg[`DT_CTL_BEN];
  wire a_oneshot = (amode_reg == `DT_MODE_ONESHOT);
  wire b_oneshot = (bmode_reg == `DT_MODE_ONESHOT);
  wire a_pre_ok = mode16 ? (apre_reg == 8'h00) : 1'b1;
  wire b_pre_ok = mode16 ? (bpre_reg == 8'h00) : 1'b1;
  wire z32 = mode32 & a_en & ~a_stall & (cnt32 == 32'h00000000);
  wire za = mode16 & a_en & ~a_stall & a_pre_ok & (acnt_reg == 16'h0000);
  wire zb = mode16 & b_en & ~b_stall & b_pre_ok & (bcnt_reg == 16'h0000);
  wire rtc_match = mode_rtc & a_en & sec_tick & (cnt32 == amatch_reg);
  wire a_zero = z32 | za;
  dt_state_t st;
  assign st = mode_rtc & a_en ? DT_ST_RTC : (a_en ? DT_ST_RUN : DT_ST_IDLE);
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  logic [31:0] cnt_next;
  always_comb begin
    cnt_next = cnt32;
    case (st)
      DT_ST_RUN: begin
        if (mode32 & ~a_stall) begin
          if (wr_ailr) begin
            cnt_next = bus.dat;
          end else if (z32) begin
            cnt_next = ilr32;
          end else begin
            cnt_next = cnt32 - 32'h00000001;
          end
        end
      end
      DT_ST_RTC: begin
        if (sec_tick) begin
          cnt_next = rtc_match ? 32'h00000000 : cnt32 + 32'h00000001;
        end
      end
      DT_ST_IDLE: begin
        // preload so that an enable starts from the written value
        if (mode32 & wr_ailr) begin
          cnt_next = bus.dat;
        end
      end
      default: cnt_next = cnt32;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acnt_reg <= `DT_RST_HALF;
      bcnt_reg <= `DT_RST_HALF;
      rtc_seen_reg <= 1'b0;
    end else if (wr_cfg & (dat_i[2:0] == `DT_CFG_RTC) & ~rtc_seen_reg) begin
      {bcnt_reg, acnt_reg} <= `DT_RTC_INIT;
      rtc_seen_reg <= 1'b1;
    end else if (~mode16) begin
      {bcnt_reg, acnt_reg} <= cnt_next;
    end else begin
      if (wr_ailr) begin
        acnt_reg <= dat_i[15:0];
      end else if (za) begin
        acnt_reg <= ailr_reg;
      end else if (a_en & ~a_stall & a_pre_ok) begin
        acnt_reg <= acnt_reg - 16'h0001;
      end
      if (wr_bilr) begin
        bcnt_reg <= dat_i[15:0];
      end else if (zb) begin
        bcnt_reg <= bilr_reg;
      end else if (b_en & ~b_stall & b_pre_ok) begin
        bcnt_reg <= bcnt_reg - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apre_reg <= `DT_RST_PRE;
      bpre_reg <= `DT_RST_PRE;
    end else begin
      if (mode16 & a_en & ~a_stall) begin
        apre_reg <= (apre_reg == 8'h00) ? apr_reg : apre_reg - 8'h01;
      end
      if (mode16 & b_en & ~b_stall) begin
        bpre_reg <= (bpre_reg == 8'h00) ? bpr_reg : bpre_reg - 8'h01;
      end
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= 3'h0;
      amode_reg <= 2'h0;
      bmode_reg <= 2'h0;
      imr_reg <= 4'h0;
      ailr_reg <= `DT_RST_HALF;
      bilr_reg <= `DT_RST_HALF;
      amatch_reg <= 32'hFFFFFFFF;
      apr_reg <= `DT_RST_PRE;
      bpr_reg <= `DT_RST_PRE;
    end else if (wr) begin
      if (wr_cfg) begin
        cfg_reg <= dat_i[2:0];
      end
      if (hit(bus.adr, `DT_OFF_AMODE)) begin
        amode_reg <= dat_i[1:0];
      end
      if (hit(bus.adr, `DT_OFF_BMODE)) begin
        bmode_reg <= dat_i[1:0];
      end
      if (hit(bus.adr, `DT_OFF_IMR)) begin
        imr_reg <= dat_i[3:0];
      end
      if (wr_ailr) begin
        ailr_reg <= dat_i[15:0];
        if (~mode16) begin
          bilr_reg <= dat_i[31:16];
        end
      end
      if (wr_bilr & mode16) begin
        bilr_reg <= dat_i[15:0];
      end
      if (hit(bus.adr, `DT_OFF_AMATCH)) begin
        amatch_reg <= mode16 ? {16'h0000, dat_i[15:0]} : dat_i;
      end
      if (hit(bus.adr, `DT_OFF_APR)) begin
        apr_reg <= dat_i[7:0];
      end
      if (hit(bus.adr, `DT_OFF_BPR)) begin
        bpr_reg <= dat_i[7:0];
      end
    end
  end
  wire a_stop = a_zero & a_oneshot;
  wire b_stop = zb & b_oneshot;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= 16'h0000;
    end else if (wr_ctl) begin
      ctl_reg <= dat_i[15:0];
    end else begin
      if (a_stop) begin
        ctl_reg[`DT_CTL_AEN] <= 1'b0;
      end
      if (b_stop) begin
        ctl_reg[`DT_CTL_BEN] <= 1'b0;
      end
    end
  end
  // write one to clear, set wins
  wire [3:0] flag_set = {rtc_match, 1'b0, zb, a_zero};
  wire [3:0] flag_clr = wr_icr ? dat_i[3:0] : 4'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ris_reg <= 4'h0;
    end else begin
      ris_reg <= (ris_reg & ~flag_clr) | flag_set;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // register read, joined count and loads outside 16-bit mode
  assign rdat = hit(bus.adr, `DT_OFF_CFG) ? {29'h0, cfg_reg} :
                hit(bus.adr, `DT_OFF_AMODE) ? {30'h0, amode_reg} :
                hit(bus.adr, `DT_OFF_BMODE) ? {30'h0, bmode_reg} :
                hit(bus.adr, `DT_OFF_CTL) ? {16'h0, ctl_reg} :
                hit(bus.adr, `DT_OFF_IMR) ? {28'h0, imr_reg} :
                hit(bus.adr, `DT_OFF_RIS) ? {28'h0, ris_reg} :
                hit(bus.adr, `DT_OFF_MIS) ? {28'h0, mis} :
                hit(bus.adr, `DT_OFF_AILR) ? (mode16 ? {16'h0, ailr_reg} : ilr32) :
                hit(bus.adr, `DT_OFF_BILR) ? {16'h0, bilr_reg} :
                hit(bus.adr, `DT_OFF_AMATCH) ? amatch_reg :
                hit(bus.adr, `DT_OFF_APR) ? {24'h0, apr_reg} :
                hit(bus.adr, `DT_OFF_BPR) ? {24'h0, bpr_reg} :
                hit(bus.adr, `DT_OFF_AR) ? (mode16 ? {16'h0, acnt_reg} : cnt32) :
                hit(bus.adr, `DT_OFF_BR) ? {16'h0, bcnt_reg} : 32'h00000000;
  logic trig_reg, irq_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= 32'h00000000;
      trig_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ack_reg <= bus.req;
      dat_o <= bus.req ? rdat : dat_o;
      trig_reg <= a_zero & ctl_reg[`DT_CTL_AOTE];
      // set wins over clear, as in the raw flags
      irq_reg <= |(((ris_reg & ~flag_clr) | flag_set) & imr_reg);
    end
  end
  assign ack_o = ack_reg;
  assign adc_trig_o = trig_reg;
  assign irq_o = irq_reg;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_zero_run;
    z32 & ~wr_ailr & ~wr_ctl & ~wr_cfg;
  endsequence
  property p_reload;
    @(posedge clk_i) disable iff (rst_i) s_zero_run |=> (cnt32 == $past(ilr32));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");
  property p_oneshot_stop;
    @(posedge clk_i) disable iff (rst_i) (z32 & a_oneshot & ~wr_ctl) |=> ~ctl_reg[`DT_CTL_AEN];
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");
  property p_flag;
    @(posedge clk_i) disable iff (rst_i) a_zero |=> ris_reg[`DT_FLAG_ATO];
  endproperty
  a_flag: assert property (p_flag) else $error("time-out flag not set");
  property p_trig;
    @(posedge clk_i) disable iff (rst_i) adc_trig_o |-> $past(a_zero & ctl_reg[`DT_CTL_AOTE]);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger without enabled zero");
  property p_stall_hold;
    @(posedge clk_i) disable iff (rst_i)
      (mode32 & a_stall & ~wr_ailr & ~wr_cfg) |=> $stable(cnt32);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("counter moved while stalled");
  property p_rollover;
    @(posedge clk_i) disable iff (rst_i) (rtc_match & ~wr_cfg) |=> (cnt32 == 32'h00000000);
  endproperty
  a_rollover: assert property (p_rollover) else $error("clock did not roll over");
  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr_icr & dat_i[`DT_FLAG_RTC] & ~rtc_match) |=> ~ris_reg[`DT_FLAG_RTC];
  endproperty
  a_clear: assert property (p_clear) else $error("clock flag not cleared");
  property p_keep;
    @(posedge clk_i) disable iff (rst_i)
      (wr_icr & ~dat_i[`DT_FLAG_ATO] & ris_reg[`DT_FLAG_ATO]) |=> ris_reg[`DT_FLAG_ATO];
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost on zero write");
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) (cyc_i & stb_i & ~ack_o) |=> ack_o ##1 ~ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack timing");
  property p_idle_load;
    @(posedge clk_i) disable iff (rst_i)
      (mode32 & ~a_en & wr_ailr) |=> (cnt32 == $past(bus.dat));
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle load not taken");
endmodule : dt_timer
`default_nettype wire

// ==== rtl/dt_cfg.svh ====
// register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DT_CFG_SVH
`define DT_CFG_SVH
`define DT_OFF_CFG 8'h00
`define DT_OFF_AMODE 8'h04
`define DT_OFF_BMODE 8'h08
`define DT_OFF_CTL 8'h0C
`define DT_OFF_IMR 8'h18
`define DT_OFF_RIS 8'h1C
`define DT_OFF_MIS 8'h20
`define DT_OFF_ICR 8'h24
`define DT_OFF_AILR 8'h28
`define DT_OFF_BILR 8'h2C
`define DT_OFF_AMATCH 8'h30
`define DT_OFF_APR 8'h38
`define DT_OFF_BPR 8'h3C
`define DT_OFF_AR 8'h48
`define DT_OFF_BR 8'h4C
`define DT_CFG_32 3'h0
`define DT_CFG_RTC 3'h1
`define DT_CFG_16 3'h4
`define DT_MODE_ONESHOT 2'h1
`define DT_MODE_PERIODIC 2'h2
`define DT_CTL_AEN 0
`define DT_CTL_ASTALL 1
`define DT_CTL_REALTIME_ENABLE_BIT 4
`define DT_CTL_AOTE 5
`define DT_CTL_BEN 8
`define DT_CTL_BSTALL 9
`define DT_FLAG_ATO 0
`define DT_FLAG_RTC 3
`define DT_RST_HALF 16'hFFFF
`define DT_RST_PRE 8'h00
`define DT_RTC_INIT 32'h00000001
`define DT_RTC_DIV 16'h8000
`endif

// ==== rtl/dt_pkg.sv ====
// types shared by the dual timer
package dt_pkg;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic we;
    logic req;
  } dt_bus_req_t;
  typedef enum logic [2:0] {
    DT_ST_IDLE = 3'b001,
    DT_ST_RUN = 3'b010,
    DT_ST_RTC = 3'b100
  } dt_state_t;
endpackage : dt_pkg

// ==== sim/dt_pin_model.sv ====
// slow reference clock source that feeds the capture pin of the dual timer
`timescale 1ns/1ps
`default_nettype none
module dt_pin_model #(
  parameter int HALF_NS = 15259
) (
  // control
  input wire logic run_i,
  // pin
  output logic capture_pin_o
);
  // ------------------------------------------------------------
  // clock generation
  // ------------------------------------------------------------
  // slow clock source
  // stands low between bursts, each phase spans several system clocks
  initial begin
    capture_pin_o = 1'b0;
    forever begin
      wait (run_i === 1'b1);
      #(HALF_NS) capture_pin_o = 1'b1;
      #(HALF_NS) capture_pin_o = 1'b0;
    end
  end
endmodule : dt_pin_model
`default_nettype wire

// ==== sim/dt_timer_bench.sv ====
// self-checking bench of the dual timer over its bus
`include "dt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dt_timer_bench;
  import dt_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000, dat_o, v, w;
  logic ack_o, irq_o, adc_trig_o, capture_pin_i, cpu_halt_i = 1'b0, run = 1'b0;
  int err_count = 0, checks = 0, n, trigs;

  dt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .capture_pin_i(capture_pin_i), .cpu_halt_i(cpu_halt_i), .irq_o(irq_o),
    .adc_trig_o(adc_trig_o));
  dt_pin_model #(.HALF_NS(60)) pin (.run_i(run), .capture_pin_o(capture_pin_i));

  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // bus and checking tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic wr,
                      input logic [3:0] s, output logic [31:0] q);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= wr;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      $display("[ERR] %0t no bus answer", $time);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, d, 1'b1, 4'hF, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 32'h00000000, 1'b0, 4'hF, q);
  endtask : rd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`DT_OFF_AILR, v); chk(v[15:0], `DT_RST_HALF);
    rd(`DT_OFF_BILR, v); chk(v[15:0], `DT_RST_HALF);
    rd(`DT_OFF_AR, v); chk(v, 32'hFFFFFFFF);
    rd(`DT_OFF_CTL, v); chk(v, 32'h00000000);
    rd(`DT_OFF_APR, v); chk(v[7:0], `DT_RST_PRE);
    rd(`DT_OFF_BPR, v); chk(v[7:0], `DT_RST_PRE);
    xfer(`DT_OFF_APR, 32'h000000AA, 1'b1, 4'h3, v);
    rd(`DT_OFF_APR, v); chk(v[7:0], `DT_RST_PRE);
    rd(8'h40, v); chk(v, 32'h00000000);
    $display("test reset done");
    wr(`DT_OFF_CFG, 32'h00000000 | `DT_CFG_32);
    wr(`DT_OFF_AILR, 32'h00010002);
    rd(`DT_OFF_BILR, v); chk(v[15:0], 16'h0001);
    rd(`DT_OFF_AR, v); chk(v, 32'h00010002);
    wr(`DT_OFF_AMODE, 32'h00000000 | `DT_MODE_ONESHOT);
    wr(`DT_OFF_BMODE, 32'h00000000 | `DT_MODE_PERIODIC);
    wr(`DT_OFF_AILR, 32'h00000014);
    wr(`DT_OFF_IMR, 32'h00000001);
    wr(`DT_OFF_CTL, 32'h00000021);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (adc_trig_o !== 1'b1 && n < 300);
    chk(adc_trig_o, 1'b1);
    repeat (4) @(posedge clk_i);
    rd(`DT_OFF_CTL, v); chk(v[0], 1'b0);
    rd(`DT_OFF_RIS, v); chk(v[0], 1'b1);
    rd(`DT_OFF_MIS, v); chk(v[0], 1'b1);
    @(negedge clk_i); chk(irq_o, 1'b1);
    @(posedge clk_i);
    wr(`DT_OFF_ICR, 32'h00000008);
    rd(`DT_OFF_RIS, v); chk(v[0], 1'b1);
    wr(`DT_OFF_ICR, 32'h00000001);
    rd(`DT_OFF_RIS, v); chk(v[0], 1'b0);
    @(negedge clk_i); chk(irq_o, 1'b0);
    @(posedge clk_i);
    $display("test one-shot done");
    wr(`DT_OFF_AMODE, 32'h00000000 | `DT_MODE_PERIODIC);
    wr(`DT_OFF_AILR, 32'h0000000A);
    wr(`DT_OFF_CTL, 32'h00000001);
    trigs = 0;
    repeat (120) begin
      @(posedge clk_i);
      if (adc_trig_o !== 1'b0) trigs++;
    end
    chk(trigs, 0);
    rd(`DT_OFF_CTL, v); chk(v[0], 1'b1);
    rd(`DT_OFF_RIS, v); chk(v[0], 1'b1);
    wr(`DT_OFF_AILR, 32'h00001000);
    rd(`DT_OFF_AR, v); chk(v <= 32'h00001000 && v > 32'h00000F00, 1'b1);
    $display("test periodic done");
    wr(`DT_OFF_CTL, 32'h00000003);
    cpu_halt_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(`DT_OFF_AR, v);
    rd(`DT_OFF_AR, w); chk(w, v);
    cpu_halt_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(`DT_OFF_AR, w); chk(w != v, 1'b1);
    $display("test stall done");
    wr(`DT_OFF_CTL, 32'h00000000);
    wr(`DT_OFF_CFG, 32'h00000000 | `DT_CFG_RTC);
    wr(`DT_OFF_CTL, 32'h00000011);
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    run <= 1'b0;
    rd(`DT_OFF_AR, v); chk(v, `DT_RTC_INIT);
    $display("test clock mode done");
    wr(`DT_OFF_CTL, 32'h00000000);
    wr(`DT_OFF_CFG, 32'h00000000 | `DT_CFG_16);
    wr(`DT_OFF_BILR, 32'h00000055);
    wr(`DT_OFF_AILR, 32'hAAAA1234);
    rd(`DT_OFF_BILR, v); chk(v[15:0], 16'h0055);
    rd(`DT_OFF_AILR, v); chk(v[15:0], 16'h1234);
    wr(`DT_OFF_AILR, 32'h00000004);
    wr(`DT_OFF_APR, 32'h000000FF);
    wr(`DT_OFF_CTL, 32'h00000001);
    rd(`DT_OFF_AR, v); chk(v, 32'h00000003);
    rd(`DT_OFF_BR, v); chk(v, 32'h00000055);
    $display("test 16-bit done");
    tally_and_finish();
  end
endmodule : dt_timer_bench
`default_nettype wire
